// file: rs422_rs485_line_control.sv
/*
  Line-interface control of the fourth serial port: standard selection,
  termination, slew control, driver switching, echo and rate checks.
  Assumes the expander write port is driven from logic on ref_clk_i and
  that UART and transceiver pins are asynchronous to it.
*/
// Function
// - Half-duplex bit at first expander line 15: 0 RS422, 1 RS485.
// - Half-duplex bit is 1 after reset, so RS485 is the start mode.
// - Termination bit, line 16, low connects 120 ohm, high disconnects.
// - Termination bit is 1 after reset, termination disconnected.
// - Second expander line 6 low reduces slew, near 250kbps; high normal.
// - RS485: request-to-send high turns driver off, low turns it on.
// - RS485: every transmitted character echoes to own receiver.
// - Serial rates up to 921.6 Kbaud are supported.
// - RS422 uses separate transmit and receive pairs, full duplex.
// - RS485 shares one pair among up to 32 nodes.
// - Control link runs at 400 or 100 kbit/s.
// - No general call, 10-bit addressing, high-speed or CBUS.
`timescale 1ns/10ps
`include "rs_line_defs.svh"
module rs422_rs485_line_control #(
  parameter int unsigned CLK_HZ        = `LC_CLK_HZ,
  parameter int unsigned MON_W         = 8,
  parameter int unsigned GAP_W         = 13,
  parameter int unsigned I2C_STD_FRAME =
    (`LC_CLK_HZ / 1000) * `LC_I2C_BYTE_BITS / `LC_I2C_STD_KBPS
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // Expander line writes
  input  wire logic                   ctrl_wr_i,
  input  wire logic [`LC_ADDR_W-1:0]  ctrl_addr_i,
  input  wire logic [`LC_LINE_W-1:0]  ctrl_line_i,
  input  wire logic                   ctrl_value_i,
  input  wire logic                   i2c_std_mode_i,
  output logic                        ctrl_ack_o,
  output logic                        ctrl_refused_o,
  output logic                        ctrl_too_fast_o,
  // UART channel side
  input  wire logic                   uart_txd_i,
  input  wire logic                   uart_rts_n_i,
  output logic                        uart_rxd_o,
  // Transceiver side
  input  wire logic                   line_rxd_i,
  output logic                        line_txd_o,
  output logic                        rts_line_n_o,
  output logic                        termination_connect_n_o,
  output logic                        driver_slow_edge_n_o,
  // Status
  output rs_line_pkg::line_mode_e     line_mode_o,
  output logic                        half_duplex_select_o,
  output logic                        tx_requested_o,
  input  wire logic                   rate_clr_i,
  output logic                        rate_over_o,
  output logic                        slew_over_o
);
  import rs_line_pkg::*;

  // Whole clock cycles per unit at a rate in units per second; the
  // division truncates, so a limit errs short rather than long
  function automatic int unsigned cycles_per(
    input int unsigned clk_hz,
    input int unsigned per_sec
  );
    return clk_hz / per_sec;
  endfunction

  // Cycle counts derived from the line and link rates
  localparam int unsigned MAX_BIT_CYC =
    cycles_per(CLK_HZ, `LC_MAX_KBAUD_X10 * 100);
  localparam int unsigned SLOW_BIT_CYC =
    cycles_per(CLK_HZ, `LC_SLOW_KBPS * 1000);
  localparam int unsigned I2C_FAST_FRAME =
    `LC_I2C_BYTE_BITS * cycles_per(CLK_HZ, `LC_I2C_FAST_KBPS * 1000);

  // Control bits as held in the expanders
  logic half_duplex_select;
  logic termination_connect_n;
  logic slew_limit_select_n;

  // Two-stage synchronisers: bit 0 txd, bit 1 rts_n, bit 2 rxd
  logic [2:0] sync_a;
  logic [2:0] sync_b;

  logic             tx_requested;
  logic [GAP_W-1:0] gap_cnt;
  drive_state_e     state;
  drive_state_e     next_state;
  logic             short_max;
  logic             short_slow;

  // Synchronised pin levels, read only from the second stage
  wire tx_s     = sync_b[0];
  wire rts_req  = ~sync_b[1];
  wire rx_s     = sync_b[2];

  // Two flip-flops on every asynchronous input
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync_a <= `LC_SYNC_RESET;
      sync_b <= `LC_SYNC_RESET;
    end else begin
      sync_a <= {line_rxd_i, uart_rts_n_i, uart_txd_i};
      sync_b <= sync_a;
    end
  end

  // Spacing limit of control writes follows the selected link speed
  wire [GAP_W-1:0] frame_cyc = i2c_std_mode_i ?
    GAP_W'(I2C_STD_FRAME) : GAP_W'(I2C_FAST_FRAME);
  wire gap_ok   = gap_cnt >= frame_cyc;

  wire gen_call = ctrl_addr_i == `LC_GENCALL_ADDR;
  wire hit_exp1 = ~gen_call & (ctrl_addr_i == `LC_EXP1_ADDR);
  wire hit_exp2 = ~gen_call & (ctrl_addr_i == `LC_EXP2_ADDR);
  wire wr_ok    = ctrl_wr_i & gap_ok;

  // One control line is written when the strobe passed the spacing
  // check, the expander address matched and the line number agrees
  function automatic logic line_write(
    input logic                  strobe,
    input logic                  exp_hit,
    input logic [`LC_LINE_W-1:0] line,
    input logic [`LC_LINE_W-1:0] want
  );
    return strobe & exp_hit & (line == want);
  endfunction

  wire wr_hd    = line_write(wr_ok, hit_exp1, ctrl_line_i, `LC_HD_LINE);
  wire wr_term  = line_write(wr_ok, hit_exp1, ctrl_line_i, `LC_TERM_LINE);
  wire wr_slew  = line_write(wr_ok, hit_exp2, ctrl_line_i, `LC_SLEW_LINE);
  wire wr_hit   = wr_hd | wr_term | wr_slew;

  // Control bits; all come out of reset high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      half_duplex_select    <= `LC_CTRL_RESET;
      termination_connect_n <= `LC_CTRL_RESET;
      slew_limit_select_n   <= `LC_CTRL_RESET;
    end else begin
      if (wr_hd) begin
        half_duplex_select <= ctrl_value_i;
      end
      if (wr_term) begin
        termination_connect_n <= ctrl_value_i;
      end
      if (wr_slew) begin
        slew_limit_select_n <= ctrl_value_i;
      end
    end
  end

  // Write spacing counter saturates so a quiet link always passes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gap_cnt <= '1;
    end else if (ctrl_wr_i) begin
      gap_cnt <= '0;
    end else if (!(&gap_cnt)) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  // Write answers, one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ack_o      <= 1'b0;
      ctrl_refused_o  <= 1'b0;
      ctrl_too_fast_o <= 1'b0;
    end else begin
      ctrl_ack_o      <= wr_hit;
      ctrl_refused_o  <= ctrl_wr_i & ~wr_hit;
      ctrl_too_fast_o <= ctrl_wr_i & ~gap_ok;
    end
  end

  wire mode485 = half_duplex_select;

  // Driver state: held off until the first request ever seen
  always_comb begin
    next_state = state;
    case (state)
      st_hold: begin
        if (rts_req) begin
          next_state = st_drive;
        end
      end
      st_listen: begin
        // Once out of hold, RS422 always drives its own pair
        if (rts_req || !mode485) begin
          next_state = st_drive;
        end
      end
      st_drive: begin
        if (!rts_req && mode485) begin
          next_state = st_listen;
        end
      end
      default: begin
        next_state = st_hold;
      end
    endcase
  end

  wire drive_next = next_state == st_drive;
  wire driver_on  = state == st_drive;

  // State and driver pin; the pin follows the next state so it
  // lines up with the registered transmit data below
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state        <= st_hold;
      rts_line_n_o <= `LC_IDLE_LEVEL;
    end else begin
      state        <= next_state;
      rts_line_n_o <= ~drive_next;
    end
  end

  // First request flag, sticky until reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_requested <= 1'b0;
    end else if (rts_req) begin
      tx_requested <= 1'b1;
    end
  end

  // Receive path: RS485 echoes own data while driving, since the
  // transceiver receiver cannot be trusted to see a quiet pair
  wire echo_sel = mode485 & drive_next;
  wire rx_pick  = echo_sel ? tx_s : rx_s;

  // Data paths are registered; transmit idles at mark when undriven
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      line_txd_o <= `LC_IDLE_LEVEL;
      uart_rxd_o <= `LC_IDLE_LEVEL;
    end else begin
      line_txd_o <= drive_next ? tx_s : `LC_IDLE_LEVEL;
      uart_rxd_o <= rx_pick;
    end
  end

  bit_width_monitor #(
    .CW      (MON_W)
  ) u_max_rate (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .line_i    (tx_s),
    .check_i   (driver_on),
    .limit_i   (MON_W'(MAX_BIT_CYC)),
    .short_o   (short_max)
  );

  bit_width_monitor #(
    .CW      (MON_W)
  ) u_slow_rate (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .line_i    (tx_s),
    .check_i   (driver_on & ~slew_limit_select_n),
    .limit_i   (MON_W'(SLOW_BIT_CYC)),
    .short_o   (short_slow)
  );

  // Rate flags are sticky; a new violation beats a clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rate_over_o <= 1'b0;
      slew_over_o <= 1'b0;
    end else begin
      rate_over_o <= short_max | (rate_over_o & ~rate_clr_i);
      slew_over_o <= short_slow | (slew_over_o & ~rate_clr_i);
    end
  end

  // Pin and status copies of the held control bits
  // active-low termination pin
  assign termination_connect_n_o = termination_connect_n;
  assign driver_slow_edge_n_o    = slew_limit_select_n;
  assign line_mode_o             = mode485 ? mode_rs485 : mode_rs422;
  assign half_duplex_select_o    = half_duplex_select;
  assign tx_requested_o          = tx_requested;

endmodule

// file: rs_line_defs.svh
/*
  Constants for the fourth serial port line-interface control: expander
  addresses and line numbers, reset levels and timing figures.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef RS_LINE_DEFS_SVH
`define RS_LINE_DEFS_SVH

// Widths of the expander write port
`define LC_ADDR_W        7
`define LC_LINE_W        5

// Seven-bit expander addresses; general call is never mapped
`define LC_EXP1_ADDR     7'h21
`define LC_EXP2_ADDR     7'h22
`define LC_GENCALL_ADDR  7'h00

// Expander line numbers of the control bits
`define LC_HD_LINE       5'h0f
`define LC_TERM_LINE     5'h10
`define LC_SLEW_LINE     5'h06

// Every control bit comes out of reset high
`define LC_CTRL_RESET    1'b1
// Idle (mark) level of serial data and inactive request-to-send
`define LC_IDLE_LEVEL    1'b1
`define LC_SYNC_RESET    3'h7

// Clock, line and control link rates
`define LC_CLK_HZ        50000000
`define LC_MAX_KBAUD_X10 9216
`define LC_SLOW_KBPS     250
`define LC_I2C_FAST_KBPS 400
`define LC_I2C_STD_KBPS  100
`define LC_I2C_BYTE_BITS 9

`endif

// file: rs_line_pkg.sv
/*
  Types shared by the line-interface control and its monitor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rs_line_pkg;

  // Electrical standard selected by the half-duplex bit
  typedef enum logic {
    mode_rs422,
    mode_rs485
  } line_mode_e;

  // Line driver control states
  typedef enum logic [1:0] {
    st_hold,
    st_listen,
    st_drive
  } drive_state_e;

endpackage

// file: bit_width_monitor.sv
/*
  Measures the width of each level run on a serial line and pulses when
  a run between two edges is shorter than a limit.
  Assumes the line is already synchronised to ref_clk_i.
*/
`timescale 1ns/10ps
`include "rs_line_defs.svh"
module bit_width_monitor #(
  parameter int unsigned CW = 8
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          line_i,
  input  wire logic          check_i,
  input  wire logic [CW-1:0] limit_i,
  output logic               short_o
);
  import rs_line_pkg::*;

  logic          prev;
  logic          armed;
  logic [CW-1:0] run;

  wire edge_seen = line_i ^ prev;
  wire run_full  = &run;

  // Run counter restarts at one on each edge and saturates on idle line
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev    <= `LC_IDLE_LEVEL;
      armed   <= 1'b0;
      run     <= '0;
      short_o <= 1'b0;
    end else begin
      prev    <= line_i;
      short_o <= edge_seen & armed & check_i & (run < limit_i);
      if (edge_seen) begin
        run   <= CW'(1);
        armed <= 1'b1; // First edge only opens a measurement
      end else if (!run_full) begin
        run <= run + 1'b1;
      end
    end
  end

endmodule

// file: rs422_rs485_line_control_asserts.sv
/*
  Port checks for the fourth serial port line control.
  Assumes a bind onto rs422_rs485_line_control.
*/
`timescale 1ns/10ps
`include "rs_line_defs.svh"
module line_control_checker (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       ctrl_wr_i,
  input wire logic [6:0] ctrl_addr_i,
  input wire logic [4:0] ctrl_line_i,
  input wire logic       ctrl_value_i,
  input wire logic       ctrl_ack_o,
  input wire logic       ctrl_refused_o,
  input wire logic       ctrl_too_fast_o,
  input wire logic       uart_rts_n_i,
  input wire logic       rts_line_n_o,
  input wire logic       termination_connect_n_o,
  input wire logic       driver_slow_edge_n_o,
  input wire logic       half_duplex_select_o,
  input wire logic       tx_requested_o
);
  // Reset is synchronous, so each check is dropped while it is low
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_duplex_write:
  assert property (ctrl_ack_o && $past(ctrl_addr_i) == `LC_EXP1_ADDR
    && $past(ctrl_line_i) == `LC_HD_LINE
    |-> half_duplex_select_o == $past(ctrl_value_i))
    else $error("half-duplex bit misses accepted write");
  chk_term_write:
  assert property (ctrl_ack_o && $past(ctrl_addr_i) == `LC_EXP1_ADDR
    && $past(ctrl_line_i) == `LC_TERM_LINE
    |-> termination_connect_n_o == $past(ctrl_value_i))
    else $error("termination bit misses accepted write");
  chk_slew_write:
  assert property (ctrl_ack_o && $past(ctrl_addr_i) == `LC_EXP2_ADDR
    && $past(ctrl_line_i) == `LC_SLEW_LINE
    |-> driver_slow_edge_n_o == $past(ctrl_value_i))
    else $error("slew bit misses accepted write");
  chk_reset_levels:
  assert property ($rose(rst_n_i) |-> half_duplex_select_o
    && termination_connect_n_o && driver_slow_edge_n_o && rts_line_n_o)
    else $error("control level wrong after reset");
  chk_first_request:
  assert property ($fell(rts_line_n_o) |-> ##[0:1] tx_requested_o)
    else $error("driver on without a request");
  chk_driver_release:
  assert property (half_duplex_select_o && $rose(uart_rts_n_i) ##1
    (half_duplex_select_o && uart_rts_n_i)[*2] |-> ##1 rts_line_n_o)
    else $error("driver still on after request ended");
  chk_gencall_refused:
  assert property (ctrl_wr_i && ctrl_addr_i == `LC_GENCALL_ADDR
    |=> ctrl_refused_o && !ctrl_ack_o)
    else $error("general call write not refused");
  chk_spacing_refused:
  assert property (ctrl_wr_i ##1 ctrl_wr_i |=> ctrl_too_fast_o
    && ctrl_refused_o) else $error("back to back write not refused");
endmodule
bind rs422_rs485_line_control line_control_checker u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctrl_wr_i(ctrl_wr_i),
  .ctrl_addr_i(ctrl_addr_i), .ctrl_line_i(ctrl_line_i),
  .ctrl_value_i(ctrl_value_i), .ctrl_ack_o(ctrl_ack_o),
  .ctrl_refused_o(ctrl_refused_o), .ctrl_too_fast_o(ctrl_too_fast_o),
  .uart_rts_n_i(uart_rts_n_i), .rts_line_n_o(rts_line_n_o),
  .termination_connect_n_o(termination_connect_n_o),
  .driver_slow_edge_n_o(driver_slow_edge_n_o),
  .half_duplex_select_o(half_duplex_select_o),
  .tx_requested_o(tx_requested_o));

// file: remote_line_node.sv
/*
  Remote node on the far end of the line pairs.
  Assumes the bench sets its data and duplex inputs.
*/
`timescale 1ns/10ps
module remote_line_node (
  input  wire logic full_i,
  input  wire logic drv_off_i,
  input  wire logic bit_i,
  output logic      line_o
);
  // one talker per pair
  // A silent pair settles to mark through the fail-safe bias
  assign line_o = (full_i || drv_off_i) ? bit_i : 1'h1;
endmodule

// file: rs422_rs485_line_control_tb.sv
/*
  Self-checking bench for the fourth serial port line control.
  Assumes the design, its package, the checker and the remote node.
*/
`timescale 1ns/10ps
module rs422_rs485_line_control_tb;
  import rs_line_pkg::*;
  localparam logic [7:0] PAT = 8'h35;
  logic       ref_clk_i, rst_n_i, ctrl_wr_i, ctrl_value_i, std_mode;
  logic       uart_txd_i, uart_rts_n_i, rate_clr_i, p_full, p_bit;
  logic [6:0] ctrl_addr_i;
  logic [4:0] ctrl_line_i;
  logic       ack, refused, too_fast, uart_rxd_o, line_rxd_i, line_txd_o;
  logic       rts_line_n_o, term_n, slow_n, hd, tx_req, rate_over, slew_o;
  logic       ak, rf, tf;
  line_mode_e line_mode;
  int         err_count = 0;
  int         compares = 0;
  // Address, line, value, accepted, half-duplex, termination, slew
  localparam logic [0:8][16:0] ROWS = {
    {7'h21, 5'h0f, 1'h0, 1'h1, 3'h3}, {7'h21, 5'h10, 1'h0, 1'h1, 3'h1},
    {7'h22, 5'h06, 1'h0, 1'h1, 3'h0}, {7'h00, 5'h0f, 1'h1, 1'h0, 3'h0},
    {7'h21, 5'h06, 1'h1, 1'h0, 3'h0}, {7'h20, 5'h0f, 1'h1, 1'h0, 3'h0},
    {7'h22, 5'h06, 1'h1, 1'h1, 3'h1}, {7'h21, 5'h10, 1'h1, 1'h1, 3'h3},
    {7'h21, 5'h0f, 1'h1, 1'h1, 3'h7}};
  rs422_rs485_line_control #(.I2C_STD_FRAME(40)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_addr_i(ctrl_addr_i), .ctrl_line_i(ctrl_line_i),
    .ctrl_value_i(ctrl_value_i), .i2c_std_mode_i(std_mode),
    .ctrl_ack_o(ack), .ctrl_refused_o(refused), .ctrl_too_fast_o(too_fast),
    .uart_txd_i(uart_txd_i), .uart_rts_n_i(uart_rts_n_i),
    .uart_rxd_o(uart_rxd_o), .line_rxd_i(line_rxd_i),
    .line_txd_o(line_txd_o), .rts_line_n_o(rts_line_n_o),
    .termination_connect_n_o(term_n), .driver_slow_edge_n_o(slow_n),
    .line_mode_o(line_mode), .half_duplex_select_o(hd),
    .tx_requested_o(tx_req), .rate_clr_i(rate_clr_i),
    .rate_over_o(rate_over), .slew_over_o(slew_o));
  remote_line_node u_node (.full_i(p_full), .drv_off_i(rts_line_n_o),
    .bit_i(p_bit), .line_o(line_rxd_i));
  // 50 MHz reference clock
  initial begin
    ref_clk_i = 1'h0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Inputs move 1 ns after the edge so no race with the design
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(string nm, logic [2:0] got, logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Strobe n cycles, gather answers, then leave the write spacing
  task automatic wr(logic [6:0] a, logic [4:0] l, logic v, int n);
    ctrl_addr_i = a;
    ctrl_line_i = l;
    ctrl_value_i = v;
    ctrl_wr_i = 1'h1;
    cyc(n);
    ctrl_wr_i = 1'h0;
    {ak, rf, tf} = {ack, refused, too_fast};
    cyc(1);
    {ak, rf, tf} = {ak, rf, tf} | {ack, refused, too_fast};
    cyc(45);
  endtask
  // Send a pattern while the remote node answers with its inverse
  task automatic burst(logic drive, logic echo);
    logic t, r;
    for (int i = 0; i < 8; i++) begin
      uart_txd_i = PAT[i];
      p_bit = ~PAT[i];
      t = drive ? PAT[i] : 1'h1;
      r = echo ? PAT[i] : ~PAT[i];
      cyc(4);
      chk("line_txd_o", line_txd_o, t);
      chk("uart_rxd_o", uart_rxd_o, r);
    end
    chk("rts_line_n_o", rts_line_n_o, !drive);
    uart_txd_i = 1'h1;
    p_bit = 1'h1;
    cyc(10);
  endtask
  task automatic runs(int n);
    repeat (4) begin
      uart_txd_i = ~uart_txd_i;
      cyc(n);
    end
  endtask
  task automatic clear_flags;
    rate_clr_i = 1'h1;
    cyc(1);
    rate_clr_i = 1'h0;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, ctrl_wr_i, ctrl_value_i, rate_clr_i, p_full} = 5'h00;
    {std_mode, uart_txd_i, uart_rts_n_i, p_bit} = 4'hf;
    ctrl_addr_i = 7'h00;
    ctrl_line_i = 5'h00;
    repeat (12) @(posedge ref_clk_i);
    #1 rst_n_i = 1'h1;
    chk("reset bits", {hd, term_n, slow_n}, 3'h7);
    chk("line_mode", line_mode, mode_rs485);
    uart_txd_i = 1'h0;
    cyc(8);
    chk("held driver", {rts_line_n_o, line_txd_o, tx_req}, 3'h6);
    uart_txd_i = 1'h1;
    $display("reset test done");
    for (int k = 0; k < 9; k++) begin
      wr(ROWS[k][16:10], ROWS[k][9:5], ROWS[k][4], 1);
      chk("answer", {ak, rf}, {ROWS[k][3], ~ROWS[k][3]});
      chk("bits", {hd, term_n, slow_n}, ROWS[k][2:0]);
      chk("line_mode", line_mode, ROWS[k][2]);
    end
    $display("table test done");
    wr(7'h21, 5'h0f, 1'h1, 2);
    chk("back to back", {rf, tf}, 3'h3);
    std_mode = 1'h0;
    wr(7'h21, 5'h0f, 1'h1, 1);
    chk("fast spacing", {ak, rf, tf}, 3'h3);
    std_mode = 1'h1;
    $display("spacing test done");
    uart_rts_n_i = 1'h0;
    cyc(4);
    chk("requested", tx_req, 3'h1);
    burst(1'h1, 1'h1);
    uart_rts_n_i = 1'h1;
    cyc(4);
    burst(1'h0, 1'h0);
    $display("half duplex test done");
    p_full = 1'h1;
    wr(7'h21, 5'h0f, 1'h0, 1);
    burst(1'h1, 1'h0);
    chk("fast bits", {rate_over, slew_o}, 3'h2);
    clear_flags();
    chk("cleared", {rate_over, slew_o}, 3'h0);
    wr(7'h22, 5'h06, 1'h0, 1);
    runs(100);
    chk("slow runs", {rate_over, slew_o}, 3'h1);
    clear_flags();
    wr(7'h22, 5'h06, 1'h1, 1);
    runs(60);
    chk("normal runs", {rate_over, slew_o}, 3'h0);
    $display("full duplex and rate test done");
    report_and_stop();
  end
endmodule
